// ==== rtl/adc_ctrl_consts.svh ====
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ----------------------------------------
// Register indices (byte address = low 8 bits of 4 x index)
// ----------------------------------------
`define CSR_INDEX        8'h70
`define RES_HIGH_INDEX   8'h71
`define RES_LOW_INDEX    8'h72
`define CSR_RESET        8'h00
`define RES_RESET        10'h000
// ----------------------------------------
// Control/status fields
// ----------------------------------------
`define CSR_DONE_BIT     7
`define CSR_RATE_BIT     6
`define CSR_ON_BIT       5
`define CSR_RSVD_BIT     4
`define CSR_CHAN_LSB     0
// ----------------------------------------
// Conversion timing in converter clocks
// ----------------------------------------
`define SAMPLE_CLOCKS    4'h3
`define RESULT_BITS      4'ha
`define DIV_SLOW_HALF    2'h1
`define DIV_FAST_HALF    2'h0
`endif

// ==== rtl/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic        readdatavalid;
  } avmm_rsp_t;
endpackage

// ==== rtl/adc_ctrl.sv ====
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
// Summary of operation
// - Input above high reference yields all-ones result, no overflow flag.
// - Input below low reference yields zero result.
// - Converter on means continuous conversion of selected channel, no restart.
// - Each conversion end loads 10-bit result and sets done flag.
// - Done flag clears on high-byte read or any control/status write with byte lane 0 enabled.
// - Result registers are overwritten by every conversion, never latched.
// - Channel change aborts conversion, clears done, restarts on new channel.
// - Rate bit 0 gives clock divided by 4; 1 divides by 2.
// - Converter-on bit clear stops conversion; set starts it.
// - Channel field value selects analog input of that index, 0 to 15.
// - High byte shows result bits 9 to 2.
// - Low register shows result bits 1:0; bits 7:2 read zero.
// - Control/status resets to zero; done flag is read-only.
// - Wait mode leaves converter running unchanged.
// - Halt disables converter; results settle after wakeup interval.
// - No interrupt output; completion is polled only.
module adc_ctrl (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Register bus
  input  wire adc_ctrl_pkg::avmm_req_t  bus_req_i,
  output      adc_ctrl_pkg::avmm_rsp_t  bus_rsp_o,
  // Analog front end
  input  wire logic                     comparator_i,
  input  wire logic                     halt_i,
  output      logic [3:0]               channel_select_o,
  output      logic [9:0]               trial_code_o,
  output      logic                     sample_o,
  output      logic                     converter_on_o
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic       cmp_meta_q;
  logic       cmp_sync_q;
  logic       halt_meta_q;
  logic       halt_sync_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_meta_q  <= 1'b0;
      cmp_sync_q  <= 1'b0;
      halt_meta_q <= 1'b0;
      halt_sync_q <= 1'b0;
    end else begin
      cmp_meta_q  <= comparator_i;
      cmp_sync_q  <= cmp_meta_q;
      halt_meta_q <= halt_i;
      halt_sync_q <= halt_meta_q;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       ack_q;
  logic [7:0] csr_q;
  logic [9:0] result_q;
  logic [7:0] word_index;
  logic       hit_csr;
  logic       hit_high;
  logic       hit_low;
  logic       access;
  logic       lane0;
  logic       csr_write;
  logic       high_read;
  logic [7:0] read_byte;

  assign access     = (bus_req_i.read | bus_req_i.write) & ~ack_q;
  assign word_index = {2'b00, bus_req_i.address[7:2]};
  assign hit_csr    = (word_index == (`CSR_INDEX & 8'h3f)) & (bus_req_i.address[7:2] == 6'h30);
  assign hit_high   = (bus_req_i.address[7:2] == 6'h31);
  assign hit_low    = (bus_req_i.address[7:2] == 6'h32);
  assign lane0      = bus_req_i.byteenable[0];
  assign csr_write  = access & bus_req_i.write & hit_csr & lane0;
  assign high_read  = access & bus_req_i.read & hit_high;
  // Unmapped addresses read zero, writes dropped
  assign read_byte  = hit_csr  ? csr_q :
                      hit_high ? result_q[9:2] :
                      hit_low  ? {6'h00, result_q[1:0]} : 8'h00;

  // ----------------------------------------
  // Control/status register
  // ----------------------------------------
  logic       done_set;
  logic       chan_change;
  logic       conv_on;
  logic       conv_fast;
  logic [3:0] chan_sel;

  assign conv_on     = csr_q[`CSR_ON_BIT] & ~halt_sync_q;
  assign conv_fast   = csr_q[`CSR_RATE_BIT];
  assign chan_sel    = csr_q[3:0];
  assign chan_change = csr_write & (bus_req_i.writedata[3:0] != chan_sel);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      csr_q <= `CSR_RESET;
    end else begin
      if (csr_write) begin
        csr_q[6:0] <= bus_req_i.writedata[6:0];
      end
      // Completion wins over a same-cycle clear; a channel change always clears
      if (done_set & ~chan_change) begin
        csr_q[`CSR_DONE_BIT] <= 1'b1;
      end else if (csr_write | high_read) begin
        csr_q[`CSR_DONE_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Bus answer: one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q     <= 1'b0;
      bus_rsp_o <= '{readdata: 32'h0000_0000, waitrequest: 1'b1, readdatavalid: 1'b0};
    end else begin
      ack_q                 <= access;
      bus_rsp_o.waitrequest <= ~access;
      bus_rsp_o.readdatavalid <= access & bus_req_i.read;
      bus_rsp_o.readdata    <= access ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  logic [1:0] div_q;
  logic       tick;
  logic [1:0] div_top;

  assign div_top = conv_fast ? 2'h1 : 2'h3;
  assign tick    = (div_q >= div_top);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (tick | ~conv_on | chan_change) ? 2'h0 : div_q + 2'h1;
    end
  end

  // ----------------------------------------
  // Successive approximation sequencer
  // ----------------------------------------
  conv_state_t state_q;
  logic [3:0]  step_q;
  logic [9:0]  trial_q;
  logic [9:0]  bit_mask;
  logic [9:0]  kept;

  assign bit_mask = 10'h200 >> step_q;
  // Comparator high means input above the trial level, so the bit stays
  assign kept     = cmp_sync_q ? trial_q : (trial_q & ~bit_mask);
  assign done_set = (state_q == ST_CONVERT) & tick & (step_q == `RESULT_BITS - 4'h1) & conv_on;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q  <= ST_IDLE;
      step_q   <= 4'h0;
      trial_q  <= 10'h000;
      result_q <= `RES_RESET;
    end else if (~conv_on | chan_change) begin
      state_q <= conv_on ? ST_SAMPLE : ST_IDLE;
      step_q  <= 4'h0;
      trial_q <= 10'h000;
    end else if (tick) begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= ST_SAMPLE;
          step_q  <= 4'h0;
        end
        ST_SAMPLE: begin
          if (step_q == `SAMPLE_CLOCKS - 4'h1) begin
            state_q <= ST_CONVERT;
            step_q  <= 4'h0;
            trial_q <= 10'h200;
          end else begin
            step_q <= step_q + 4'h1;
          end
        end
        ST_CONVERT: begin
          if (step_q == `RESULT_BITS - 4'h1) begin
            result_q <= kept;
            state_q  <= ST_SAMPLE;
            step_q   <= 4'h0;
            trial_q  <= 10'h000;
          end else begin
            trial_q <= kept | (bit_mask >> 1);
            step_q  <= step_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Front-end outputs, all registered
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_select_o <= 4'h0;
      trial_code_o     <= 10'h000;
      sample_o         <= 1'b0;
      converter_on_o   <= 1'b0;
    end else begin
      channel_select_o <= chan_sel;
      trial_code_o     <= trial_q;
      sample_o         <= (state_q == ST_SAMPLE);
      converter_on_o   <= conv_on;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CSR_RESET_ZERO: assert property (@(posedge clk_i) $rose(rst_b_i) |-> csr_q == 8'h00)
    else $error("csr not zero after reset");
  AST_DONE_ON_END: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done_set & ~chan_change |=> csr_q[7] && result_q == $past(kept))
    else $error("done or result missing at conversion end");
  AST_HIGH_READ_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    high_read & ~done_set |=> !csr_q[7])
    else $error("high read did not clear done");
  AST_CSR_WRITE_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    csr_write & ~done_set |=> !csr_q[7])
    else $error("csr write did not clear done");
  AST_CHAN_ABORT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    chan_change & conv_on |=> state_q == ST_SAMPLE && step_q == 4'h0 && !csr_q[7])
    else $error("channel change did not restart");
  AST_OFF_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !conv_on |=> state_q == ST_IDLE)
    else $error("converter kept running while off");
  // A rate write just after a tick moves the next tick, so it excuses the count
  AST_FAST_DIV: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tick & conv_fast & conv_on & ~csr_write |=> !tick ##1 (tick || $past(csr_write) || !$past(conv_on)))
    else $error("fast divider not by two");
  AST_SLOW_DIV: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tick & ~conv_fast & conv_on & ~csr_write |=> !tick ##1 (!tick || $past(csr_write))
      ##1 (!tick || $past(csr_write) || $past(csr_write, 2)))
    else $error("slow divider not by four");
  AST_LOW_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bus_rsp_o.readdatavalid & $past(hit_low) |-> bus_rsp_o.readdata[31:2] == 30'h0)
    else $error("low register upper bits not zero");

  // ----------------------------------------
  // Register path and sequencing checks
  // ----------------------------------------
  // Read data is registered, so it shows the state of the decode cycle
  AST_CSR_READBACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access & bus_req_i.read & hit_csr |=> bus_rsp_o.readdata[7:0] == $past(csr_q))
    else $error("csr read data wrong");
  AST_HIGH_DATA: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access & bus_req_i.read & hit_high |=> bus_rsp_o.readdata[7:0] == $past(result_q[9:2]))
    else $error("high register data wrong");
  AST_LOW_DATA: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access & bus_req_i.read & hit_low |=> bus_rsp_o.readdata[1:0] == $past(result_q[1:0]))
    else $error("low register data wrong");
  AST_ANSWER_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access |=> !bus_rsp_o.waitrequest ##1 bus_rsp_o.waitrequest)
    else $error("bus answer not exactly one cycle");
  AST_WRITE_STORES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    csr_write |=> csr_q[6:0] == $past(bus_req_i.writedata[6:0]))
    else $error("csr write not stored");
  AST_CHAN_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    csr_write |=> ##1 channel_select_o == $past(bus_req_i.writedata[3:0], 2))
    else $error("channel output does not follow field");
  AST_DONE_STEADY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !done_set & !csr_write & !high_read |=> $stable(csr_q[7]))
    else $error("done changed without cause");
  AST_NO_DONE_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !conv_on & !csr_q[7] |=> !csr_q[7])
    else $error("done set while converter off");
  AST_RESULT_HELD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !done_set |=> $stable(result_q))
    else $error("result changed outside conversion end");
  AST_IDLE_START: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_IDLE && conv_on && tick && !chan_change |=> state_q == ST_SAMPLE)
    else $error("converter did not start");
  AST_RESTART_AFTER_END: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done_set & ~chan_change |=> state_q == ST_SAMPLE && step_q == 4'h0)
    else $error("conversion not repeated");
  AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_SAMPLE && tick && step_q == `SAMPLE_CLOCKS - 4'h1 && conv_on && !chan_change
      |=> state_q == ST_CONVERT && trial_q == 10'h200)
    else $error("first trial not the top bit");
  AST_STEP_RANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_q != ST_CONVERT || step_q < `RESULT_BITS) && (state_q != ST_SAMPLE || step_q < `SAMPLE_CLOCKS))
    else $error("step count out of range");
  AST_HALT_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_sync_q |=> !converter_on_o)
    else $error("converter on during halt");
endmodule // adc_ctrl

// ==== tb/adc_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module adc_ctrl_tb_top;
  import adc_ctrl_pkg::*;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  localparam logic [7:0] CSR  = 8'(`CSR_INDEX << 2);
  localparam logic [7:0] HI   = 8'(`RES_HIGH_INDEX << 2);
  localparam logic [7:0] LO   = 8'(`RES_LOW_INDEX << 2);
  localparam int         CONV = `SAMPLE_CLOCKS + `RESULT_BITS;
  logic       clk_i        = 1'b0;
  logic       rst_b_i      = 1'b0;
  avmm_req_t  req          = '0;
  avmm_rsp_t  rsp;
  logic       comparator_i = 1'b0;
  logic       halt_i       = 1'b0;
  logic [3:0] chan;
  logic [9:0] trial;
  logic       sample;
  logic       on;
  logic [7:0] q;
  int         n;
  int         mismatches   = 0;
  int         n_checks     = 0;

  always #10 clk_i = ~clk_i;

  adc_ctrl dut (
    .clk_i            (clk_i),
    .rst_b_i          (rst_b_i),
    .bus_req_i        (req),
    .bus_rsp_o        (rsp),
    .comparator_i     (comparator_i),
    .halt_i           (halt_i),
    .channel_select_o (chan),
    .trial_code_o     (trial),
    .sample_o         (sample),
    .converter_on_o   (on)
  );

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    req.address    <= a;
    req.read       <= ~w;
    req.write      <= w;
    req.writedata  <= {24'h0, d};
    req.byteenable <= 4'hf;
    @(posedge clk_i);
    while (rsp.waitrequest !== 1'b0) @(posedge clk_i);
    q = rsp.readdata[7:0];
    if (!w) cmp("readdatavalid", 10'h1, {9'h0, rsp.readdatavalid});
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    acc(1'b0, a, 8'h00);
    cmp(what, {2'b00, e}, {2'b00, q});
  endtask

  task automatic wait_done;
    do acc(1'b0, CSR, 8'h00); while (q[7] !== 1'b1);
  endtask

  // Cycles until the next rise of the sample phase
  task automatic to_rise(output int c);
    c = 0;
    while (sample !== 1'b0) begin
      @(posedge clk_i);
      c++;
    end
    while (sample !== 1'b1) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Whole sequence needs well under a thousand cycles; margin for slow polls
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(CSR, 8'h00, "csr reset");
    rd(HI, 8'h00, "high reset");
    rd(LO, 8'h00, "low reset");
    rd(8'h00, 8'h00, "unmapped read");
    wr(8'h00, 8'hff);
    wr(HI, 8'h55);
    rd(HI, 8'h00, "high write ignored");
    wr(CSR, 8'h8a);
    rd(CSR, 8'h0a, "done not writable");
    for (int c = 0; c < 16; c++) begin
      wr(CSR, 8'(c));
      @(posedge clk_i);
      cmp("channel", 10'(c), {6'h0, chan});
    end
    cmp("converter off", 10'h0, {9'h0, on});
    comparator_i <= 1'b1;
    wr(CSR, 8'h65);
    repeat (2) @(posedge clk_i);
    cmp("converter on", 10'h1, {9'h0, on});
    to_rise(n);
    to_rise(n);
    cmp("fast period", 10'(2 * CONV), 10'(n));
    wait_done();
    rd(LO, 8'h03, "full scale low");
    rd(HI, 8'hff, "full scale high");
    rd(CSR, 8'h65, "done cleared by high read");
    comparator_i <= 1'b0;
    wr(CSR, 8'h25);
    to_rise(n);
    to_rise(n);
    cmp("slow period", 10'(4 * CONV), 10'(n));
    wait_done();
    rd(LO, 8'h00, "zero low");
    rd(HI, 8'h00, "zero high");
    wait_done();
    rd(HI, 8'h00, "8-bit high");
    rd(CSR, 8'h25, "done cleared by 8-bit read");
    wait_done();
    wr(CSR, 8'h25);
    rd(CSR, 8'h25, "done cleared by write");
    // Change channel in mid approximation: sampling must restart at once
    to_rise(n);
    repeat (20) @(posedge clk_i);
    wr(CSR, 8'h27);
    cmp("restart sampling", 10'h1, {9'h0, sample});
    rd(CSR, 8'h27, "done cleared by channel change");
    cmp("new channel", 10'h7, {6'h0, chan});
    while (sample !== 1'b0) @(posedge clk_i);
    cmp("first trial", 10'h200, trial);
    halt_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    cmp("halted", 10'h0, {9'h0, on});
    halt_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    cmp("woken", 10'h1, {9'h0, on});
    wr(CSR, 8'h07);
    repeat (60) @(posedge clk_i);
    cmp("stopped", 10'h0, {9'h0, on});
    rd(CSR, 8'h07, "no done while off");
    close_out();
  end
endmodule // adc_ctrl_tb_top
